// [verilog/boot_pkg.sv]
/*
 * Shared types and constants for boot strap decoding and power-state control.
 * Assumes the divider ratio arrives as a whole number of hundredths (0 to 100).
 */
package boot_pkg;

	// ----------------------------------------------------------------
	// Divider ratio bands, in hundredths
	// ----------------------------------------------------------------
	localparam logic [6:0] RATIO_00 = 7'h00;	// 0.00
	localparam logic [6:0] RATIO_10 = 7'h0A;	// 0.10
	localparam logic [6:0] RATIO_18 = 7'h12;	// 0.18
	localparam logic [6:0] RATIO_20 = 7'h14;	// 0.20
	localparam logic [6:0] RATIO_28 = 7'h1C;	// 0.28
	localparam logic [6:0] RATIO_30 = 7'h1E;	// 0.30
	localparam logic [6:0] RATIO_38 = 7'h26;	// 0.38
	localparam logic [6:0] RATIO_40 = 7'h28;	// 0.40
	localparam logic [6:0] RATIO_48 = 7'h30;	// 0.48
	localparam logic [6:0] RATIO_50 = 7'h32;	// 0.50
	localparam logic [6:0] RATIO_58 = 7'h3A;	// 0.58
	localparam logic [6:0] RATIO_60 = 7'h3C;	// 0.60
	localparam logic [6:0] RATIO_68 = 7'h44;	// 0.68
	localparam logic [6:0] RATIO_70 = 7'h46;	// 0.70
	localparam logic [6:0] RATIO_78 = 7'h4E;	// 0.78
	localparam logic [6:0] RATIO_80 = 7'h50;	// 0.80
	localparam logic [6:0] RATIO_88 = 7'h58;	// 0.88
	localparam logic [6:0] RATIO_90 = 7'h5A;	// 0.90
	localparam logic [6:0] RATIO_100 = 7'h64;	// 1.00

	// ----------------------------------------------------------------
	// Default profile figures
	// ----------------------------------------------------------------
	localparam logic [6:0] SRC_W_NONE = 7'h00;
	localparam logic [6:0] SRC_W_15   = 7'h0F;	// 5 V at 3 A
	localparam logic [6:0] SRC_W_45   = 7'h2D;
	localparam logic [6:0] SRC_W_60   = 7'h3C;
	localparam logic [3:0] VMASK_NONE = 4'h0;
	localparam logic [3:0] VMASK_5V   = 4'h1;	// Bit 0 5 V, 1 9 V, 2 15 V, 3 20 V
	localparam logic [3:0] VMASK_ALL  = 4'hF;
	localparam logic [4:0] SNK_V_MIN  = 5'h05;	// Volts
	localparam logic [4:0] SNK_V_MAX  = 5'h14;	// Volts
	localparam logic [4:0] SNK_I_MIN  = 5'h09;	// Tenths of an amp
	localparam logic [4:0] SNK_I_MAX  = 5'h1E;	// Tenths of an amp
	localparam logic [4:0] ZERO5      = 5'h00;

	// ----------------------------------------------------------------
	// Enumerations
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		db_no_response,
		db_wait_supply_internal,
		db_wait_supply_external,
		db_controller_wait_internal,
		db_controller_wait_external,
		db_no_wait
	} db_mode_e;

	typedef enum logic [2:0] {
		CFG_SAFE,
		CFG_INFINITE_WAIT,
		CFG_SET1,
		CFG_SET2,
		CFG_SET3,
		CFG_SET4,
		CFG_SET5,
		CFG_RESERVED
	} default_cfg_e;

	typedef enum logic [1:0] {
		PWR_ACTIVE,
		PWR_IDLE,
		PWR_SLEEP
	} power_state_e;

	typedef enum logic [1:0] {
		CLK_12MHZ,
		CLK_4_6MHZ,
		CLK_100KHZ
	} core_clk_e;

	// ----------------------------------------------------------------
	// Carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic         valid;	// Ratio fell inside a listed band
		db_mode_e     mode;
		default_cfg_e cfg;
	} strap_s;

	typedef struct packed {
		logic       dfp_en;
		logic       ufp_en;
		logic       ext_switch;
		logic       pd_en;
		logic       altmode_en;
		logic [6:0] src_watts;
		logic [3:0] src_vmask;
		logic [4:0] snk_v_min;
		logic [4:0] snk_v_max;
		logic [4:0] snk_i_min;
		logic [4:0] snk_i_max;
	} profile_s;

	typedef struct packed {
		core_clk_e core_clk;
		logic      osc_24m_en;
		logic      osc_100k_en;
		logic      typec_det_en;
		logic      pd_en;
		logic      i2c_en;
		logic      spi_en;
	} pwr_ctrl_s;

endpackage

// [verilog/strap_decoder.sv]
/*
 * Combinational decode of strap pin and divider ratio into dead-battery mode
 * and default configuration. Assumes a stable, sampled ratio at its input.
 */
`timescale 1ns/100ps

module strap_decoder
(
	// Strap inputs
	input  wire logic                strap_pin_i,
	input  wire logic [6:0]          ratio_i,
	// Decoded result
	output boot_pkg::strap_s         strap_o
);
	import boot_pkg::*;

	// ----------------------------------------------------------------
	// Band test
	// ----------------------------------------------------------------
	function automatic logic in_band(input logic [6:0] r, input logic [6:0] lo,
		input logic [6:0] hi);
		in_band = (r >= lo) && (r <= hi);
	endfunction

	// ----------------------------------------------------------------
	// Decode table
	// ----------------------------------------------------------------
	// Gaps between bands come out invalid
	always_comb
	begin
		strap_o = '{valid: 1'b0, mode: db_no_response, cfg: CFG_SAFE};
		if (strap_pin_i)
		begin
			if (in_band(ratio_i, RATIO_00, RATIO_18))
				strap_o = '{1'b1, db_no_response, CFG_SAFE};
			else if (in_band(ratio_i, RATIO_20, RATIO_28))
				strap_o = '{1'b1, db_wait_supply_internal, CFG_SAFE};
			else if (in_band(ratio_i, RATIO_30, RATIO_38))
				strap_o = '{1'b1, db_controller_wait_internal, CFG_INFINITE_WAIT};
			else if (in_band(ratio_i, RATIO_40, RATIO_48))
				strap_o = '{1'b1, db_wait_supply_external, CFG_SAFE};
			else if (in_band(ratio_i, RATIO_50, RATIO_58))
				strap_o = '{1'b1, db_controller_wait_external, CFG_INFINITE_WAIT};
			else if (in_band(ratio_i, RATIO_60, RATIO_100))
				strap_o = '{1'b1, db_no_wait, CFG_SAFE};
		end
		else
		begin
			if (in_band(ratio_i, RATIO_10, RATIO_18))
				strap_o = '{1'b1, db_no_response, CFG_SET1};
			else if (in_band(ratio_i, RATIO_20, RATIO_28))
				strap_o = '{1'b1, db_no_response, CFG_SET2};
			else if (in_band(ratio_i, RATIO_30, RATIO_38))
				strap_o = '{1'b1, db_controller_wait_internal, CFG_INFINITE_WAIT};
			else if (in_band(ratio_i, RATIO_40, RATIO_48))
				strap_o = '{1'b1, db_no_wait, CFG_SET3};
			else if (in_band(ratio_i, RATIO_50, RATIO_58))
				strap_o = '{1'b1, db_controller_wait_external, CFG_INFINITE_WAIT};
			else if (in_band(ratio_i, RATIO_60, RATIO_68))
				strap_o = '{1'b1, db_no_response, CFG_SET4};
			else if (in_band(ratio_i, RATIO_70, RATIO_78))
				strap_o = '{1'b1, db_no_wait, CFG_RESERVED};
			else if (in_band(ratio_i, RATIO_80, RATIO_88))
				strap_o = '{1'b1, db_no_response, CFG_RESERVED};
			else if (in_band(ratio_i, RATIO_90, RATIO_100))
				strap_o = '{1'b1, db_no_wait, CFG_SET5};
		end
	end

endmodule // strap_decoder

// [verilog/boot_strap_power_state_ctrl.sv]
/*
 * Boot strap capture, dead-battery start-up sequencing, default configuration
 * fallback and Active/Idle/Sleep power-state control.
 * Assumes all inputs synchronous to clk_sys_i; the ratio is valid when
 * ratio_valid_i is high; configuration loading is done by an outside engine.
 */
`timescale 1ns/100ps

module boot_strap_power_state_ctrl
(
	// Clock and reset
	input  wire logic                   clk_sys_i,
	input  wire logic                   rst_n_i,
	// Strap inputs
	input  wire logic                   strap_pin_i,
	input  wire logic [6:0]             strap_divider_input_i,
	input  wire logic                   ratio_valid_i,
	// Supply status
	input  wire logic                   main_supply_input_i,
	input  wire logic [1:0]             vbus_present_i,
	input  wire logic                   regulated_3v3_from_vbus_i,
	// Configuration loader handshake
	input  wire logic                   cfg_loaded_i,
	input  wire logic                   cfg_failed_i,
	input  wire logic                   cfg_ext_switch_i,
	// Power-state requests and wake sources
	input  wire logic                   idle_req_i,
	input  wire logic                   sleep_req_i,
	input  wire logic                   port_connected_i,
	input  wire logic                   attach_detach_i,
	input  wire logic                   pd_msg_i,
	input  wire logic                   i2c_traffic_i,
	// Boot status
	output boot_pkg::strap_s            strap_o,
	output logic                        cfg_load_req_o,
	output logic                        boot_done_o,
	output logic                        default_applied_o,
	output boot_pkg::profile_s          profile_o,
	// Power path controls
	output logic [1:0]                  int_switch_en_o,
	output logic                        port1_ext_path_ctrl_o,
	output logic                        port2_ext_path_ctrl_o,
	output logic                        ports_disabled_o,
	output logic                        legacy_sink_o,
	output logic                        sink_only_o,
	// Power state
	output boot_pkg::power_state_e      pwr_state_o,
	output boot_pkg::pwr_ctrl_s         pwr_ctrl_o,
	output logic                        pd_msg_discard_o
);
	import boot_pkg::*;

	// ----------------------------------------------------------------
	// Types and storage
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		BOOT_SAMPLE,
		BOOT_HOLD,
		BOOT_LOAD,
		BOOT_WAIT_CFG,
		BOOT_RUN
	} boot_state_e;

	boot_state_e  boot_ff, nxt_boot;
	power_state_e pwr_ff, nxt_pwr;
	strap_s       strap_ff;
	strap_s       strap_dec;
	profile_s     profile_ff;
	logic         from_cfg_ff;	// Running on a loaded configuration
	logic         ext_sw_ff;	// Switch kind picked by loaded configuration
	logic         default_ff;
	logic [1:0]   int_sw_ff;
	logic [1:0]   ext_sw_en_ff;
	logic         disabled_ff;
	logic         legacy_ff;
	logic         sink_only_ff;
	logic         req_ff, done_ff;
	logic         discard_ff;
	pwr_ctrl_s    pwr_ctrl_ff;

	// ----------------------------------------------------------------
	// Default profile table
	// ----------------------------------------------------------------
	function automatic profile_s profile_of(input default_cfg_e c);
		profile_s p;
		p = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, SRC_W_NONE, VMASK_NONE, ZERO5, ZERO5, ZERO5,
			ZERO5};
		unique case (c)
			CFG_SET1: p = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, SRC_W_15, VMASK_5V,
				ZERO5, ZERO5, ZERO5, ZERO5};
			CFG_SET2: p = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0, SRC_W_45, VMASK_ALL,
				ZERO5, ZERO5, ZERO5, ZERO5};
			CFG_SET3: p = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, SRC_W_NONE, VMASK_NONE,
				SNK_V_MIN, SNK_V_MAX, SNK_I_MIN, SNK_I_MAX};
			CFG_SET4: p = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0, SRC_W_60, VMASK_ALL,
				ZERO5, ZERO5, ZERO5, ZERO5};
			CFG_SET5: p = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0, SRC_W_15, VMASK_5V,
				SNK_V_MIN, SNK_V_MAX, SNK_I_MIN, SNK_I_MAX};
			default: p = p;	// Safe, infinite wait and reserved carry no profile
		endcase
		return p;
	endfunction

	// ----------------------------------------------------------------
	// Strap decoder
	// ----------------------------------------------------------------
	strap_decoder u_strap_decoder
	(
		.strap_pin_i (strap_pin_i),
		.ratio_i     (strap_divider_input_i),
		.strap_o     (strap_dec)
	);

	// ----------------------------------------------------------------
	// Boot decode wires
	// ----------------------------------------------------------------
	wire logic on_vbus      = ~main_supply_input_i;	// Dead-battery supply
	wire logic mode_nores   = (strap_ff.mode == db_no_response);
	wire logic mode_wait_i  = (strap_ff.mode == db_wait_supply_internal);
	wire logic mode_wait_e  = (strap_ff.mode == db_wait_supply_external);
	wire logic mode_ecw_i   = (strap_ff.mode == db_controller_wait_internal);
	wire logic mode_ecw_e   = (strap_ff.mode == db_controller_wait_external);
	wire logic hold_boot    = on_vbus & (mode_nores | mode_wait_i | mode_wait_e);
	wire logic ecw_mode     = mode_ecw_i | mode_ecw_e;
	wire logic infinite_cfg = (strap_ff.cfg == CFG_INFINITE_WAIT);
	wire logic safe_cfg     = (strap_ff.cfg == CFG_SAFE) | (strap_ff.cfg == CFG_RESERVED);
	// Dead-battery switch closed before configuration, per mode
	wire logic db_int_close = on_vbus & (mode_wait_i | mode_ecw_i);
	wire logic db_ext_close = on_vbus & (mode_wait_e | mode_ecw_e);
	wire logic running      = (boot_ff == BOOT_RUN);
	// Switch kind once running: loaded configuration or default profile
	wire logic run_ext      = from_cfg_ff ? ext_sw_ff : profile_ff.ext_switch;
	wire logic run_close    = running & on_vbus & ~(default_ff & safe_cfg);
	wire logic close_int    = (~running & db_int_close) | (run_close & ~run_ext);
	wire logic close_ext    = (~running & db_ext_close) | (run_close & run_ext);

	// ----------------------------------------------------------------
	// Boot sequencer next state
	// ----------------------------------------------------------------
	always_comb
	begin
		nxt_boot = boot_ff;
		unique case (boot_ff)
			BOOT_SAMPLE:   if (ratio_valid_i) nxt_boot = BOOT_HOLD;
			BOOT_HOLD:     if (!hold_boot) nxt_boot = BOOT_LOAD;
			BOOT_LOAD:
				if (cfg_loaded_i)
					nxt_boot = BOOT_RUN;
				else if (cfg_failed_i && !ecw_mode)
					nxt_boot = infinite_cfg ? BOOT_WAIT_CFG : BOOT_RUN;
			BOOT_WAIT_CFG: if (cfg_loaded_i) nxt_boot = BOOT_RUN;
			BOOT_RUN:      nxt_boot = BOOT_RUN;
		endcase
	end

	// ----------------------------------------------------------------
	// Boot sequencer registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			boot_ff <= BOOT_SAMPLE;
		else
			boot_ff <= nxt_boot;
	end

	// Strap captured once, held until next power-on
	always_ff @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			strap_ff <= '{valid: 1'b0, mode: db_no_response, cfg: CFG_SAFE};
		else if (boot_ff == BOOT_SAMPLE && ratio_valid_i)
			strap_ff <= strap_dec;
	end

	// Loaded configuration versus strap default
	always_ff @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			from_cfg_ff <= 1'b0;
			ext_sw_ff   <= 1'b0;
			default_ff  <= 1'b0;
			profile_ff  <= profile_of(CFG_SAFE);
		end
		else if (!running && nxt_boot == BOOT_RUN)
		begin
			from_cfg_ff <= cfg_loaded_i;
			ext_sw_ff   <= cfg_ext_switch_i;
			default_ff  <= ~cfg_loaded_i;
			profile_ff  <= cfg_loaded_i ? profile_of(CFG_SAFE) : profile_of(strap_ff.cfg);
		end
	end

	// Loader request stays up while loading or waiting
	always_ff @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			{req_ff, done_ff} <= 2'h0;
		else
			{req_ff, done_ff} <= {(nxt_boot == BOOT_LOAD) | (nxt_boot == BOOT_WAIT_CFG),
				nxt_boot == BOOT_RUN};
	end

	// ----------------------------------------------------------------
	// Power path controls
	// ----------------------------------------------------------------
	// Only the port receiving VBUS gets its path closed
	always_ff @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			int_sw_ff    <= 2'h0;
			ext_sw_en_ff <= 2'h0;
			disabled_ff  <= 1'b1;
			legacy_ff    <= 1'b0;
			sink_only_ff <= 1'b0;
		end
		else
		begin
			int_sw_ff    <= close_int ? vbus_present_i : 2'h0;
			ext_sw_en_ff <= close_ext ? vbus_present_i : 2'h0;
			disabled_ff  <= ~running | (default_ff & safe_cfg);
			legacy_ff    <= running & default_ff & safe_cfg & on_vbus;
			sink_only_ff <= regulated_3v3_from_vbus_i;
		end
	end

	// ----------------------------------------------------------------
	// Power-state wake and entry wires
	// ----------------------------------------------------------------
	wire logic sleep_ok   = sleep_req_i & ~port_connected_i;
	wire logic wake_idle  = attach_detach_i | pd_msg_i | i2c_traffic_i;
	wire logic wake_sleep = attach_detach_i | i2c_traffic_i;
	// PD message alone caused the wake
	wire logic pd_wake    = (pwr_ff == PWR_IDLE) & pd_msg_i & ~attach_detach_i &
		~i2c_traffic_i;

	// ----------------------------------------------------------------
	// Power-state next state
	// ----------------------------------------------------------------
	// Low-power states are entered only once boot has finished
	always_comb
	begin
		nxt_pwr = pwr_ff;
		unique case (pwr_ff)
			PWR_ACTIVE:
				if (running && sleep_ok)
					nxt_pwr = PWR_SLEEP;
				else if (running && idle_req_i)
					nxt_pwr = PWR_IDLE;
			PWR_IDLE:
				if (wake_idle)
					nxt_pwr = PWR_ACTIVE;
				else if (sleep_ok)
					nxt_pwr = PWR_SLEEP;
			PWR_SLEEP:
				if (wake_sleep)
					nxt_pwr = PWR_ACTIVE;
			default: nxt_pwr = PWR_ACTIVE;
		endcase
	end

	// ----------------------------------------------------------------
	// Power-state registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			pwr_ff     <= PWR_ACTIVE;
			discard_ff <= 1'b0;
		end
		else
		begin
			pwr_ff     <= nxt_pwr;
			discard_ff <= pd_wake;
		end
	end

	// Clocking and feature enables follow the next state
	always_ff @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			pwr_ctrl_ff <= '{CLK_12MHZ, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
		else
		begin
			unique case (nxt_pwr)
				PWR_IDLE:  pwr_ctrl_ff <= '{CLK_4_6MHZ, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1,
					1'b0};
				PWR_SLEEP: pwr_ctrl_ff <= '{CLK_100KHZ, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0,
					1'b0};
				default:   pwr_ctrl_ff <= '{CLK_12MHZ, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1,
					1'b1};
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign strap_o               = strap_ff;
	assign cfg_load_req_o        = req_ff;
	assign boot_done_o           = done_ff;
	assign default_applied_o     = default_ff;
	assign profile_o             = profile_ff;
	assign int_switch_en_o       = int_sw_ff;
	assign port1_ext_path_ctrl_o = ext_sw_en_ff[0];
	assign port2_ext_path_ctrl_o = ext_sw_en_ff[1];
	assign ports_disabled_o      = disabled_ff;
	assign legacy_sink_o         = legacy_ff;
	assign sink_only_o           = sink_only_ff;
	assign pwr_state_o           = pwr_ff;
	assign pwr_ctrl_o            = pwr_ctrl_ff;
	assign pd_msg_discard_o      = discard_ff;

endmodule // boot_strap_power_state_ctrl

// [testbench/boot_ctrl_monitor.sv]
/* Checker on the top module's ports.
   Bound from the bench; needs only the ports. */
`timescale 1ns/100ps

module boot_ctrl_monitor
(
	// Clock, reset and inputs
	input wire logic                   clk_sys_i,
	input wire logic                   rst_n_i,
	input wire logic                   main_supply_input_i,
	input wire logic [1:0]             vbus_present_i,
	input wire logic                   regulated_3v3_from_vbus_i,
	input wire logic                   cfg_loaded_i,
	input wire logic                   port_connected_i,
	input wire logic                   attach_detach_i,
	input wire logic                   pd_msg_i,
	input wire logic                   i2c_traffic_i,
	// Design outputs
	input wire boot_pkg::strap_s       strap_o,
	input wire logic                   cfg_load_req_o,
	input wire logic                   boot_done_o,
	input wire logic                   default_applied_o,
	input wire logic [1:0]             int_switch_en_o,
	input wire logic                   port1_ext_path_ctrl_o,
	input wire logic                   port2_ext_path_ctrl_o,
	input wire logic                   sink_only_o,
	input wire boot_pkg::power_state_e pwr_state_o,
	input wire boot_pkg::pwr_ctrl_s    pwr_ctrl_o,
	input wire logic                   pd_msg_discard_o
);
	import boot_pkg::*;
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);
	// Strap modes that hold start-up on VBUS
	wire hold_m = strap_o.mode inside {db_no_response, db_wait_supply_internal,
		db_wait_supply_external};
	// Boot sequencing
	a_hold_no_load: assert property (!boot_done_o && !main_supply_input_i && hold_m
		|-> !cfg_load_req_o) else $error("load while held");
	a_noresp_open: assert property (!boot_done_o && strap_o.mode == db_no_response
		|-> {int_switch_en_o, port1_ext_path_ctrl_o, port2_ext_path_ctrl_o} == 4'h0)
		else $error("switch closed");
	a_ext_path_map: assert property (!boot_done_o && !main_supply_input_i
		&& !$past(main_supply_input_i) && $past(strap_o.mode) == db_wait_supply_external
		|-> {port1_ext_path_ctrl_o, port2_ext_path_ctrl_o, int_switch_en_o}
		== {$past(vbus_present_i[0]), $past(vbus_present_i[1]), 2'h0})
		else $error("ext path wrong");
	a_infinite_hold: assert property (cfg_load_req_o && !cfg_loaded_i
		&& strap_o.cfg == CFG_INFINITE_WAIT |=> !boot_done_o) else $error("left boot early");
	a_load_done: assert property (cfg_load_req_o && cfg_loaded_i
		|=> boot_done_o && !default_applied_o) else $error("load not taken");
	// Power states
	a_sink_follow: assert property ($changed(regulated_3v3_from_vbus_i)
		|=> sink_only_o == $past(regulated_3v3_from_vbus_i)) else $error("sink-only wrong");
	a_sleep_entry: assert property ($changed(pwr_state_o) && pwr_state_o == PWR_SLEEP
		|-> !$past(port_connected_i)) else $error("sleep while connected");
	a_sleep_ctrl: assert property (pwr_state_o == PWR_SLEEP
		|-> pwr_ctrl_o == {CLK_100KHZ, 6'h18}) else $error("sleep ctrl");
	a_idle_ctrl: assert property (pwr_state_o == PWR_IDLE
		|-> pwr_ctrl_o == {CLK_4_6MHZ, 6'h3A}) else $error("idle ctrl");
	a_active_ctrl: assert property (pwr_state_o == PWR_ACTIVE
		|-> pwr_ctrl_o == {CLK_12MHZ, 6'h3F}) else $error("active ctrl");
	a_idle_wake: assert property (pwr_state_o == PWR_IDLE
		&& (attach_detach_i || pd_msg_i || i2c_traffic_i) |=> pwr_state_o == PWR_ACTIVE)
		else $error("idle did not wake");
	a_sleep_pd_deaf: assert property (pwr_state_o == PWR_SLEEP && !attach_detach_i
		&& !i2c_traffic_i |=> pwr_state_o == PWR_SLEEP) else $error("sleep left wrongly");
	a_pd_discard: assert property (pd_msg_discard_o |-> pwr_state_o == PWR_ACTIVE
		&& $past(pwr_state_o) == PWR_IDLE && $past(pd_msg_i)) else $error("bad discard");
	// Main scenarios reached
	c_discard: cover property (pd_msg_discard_o);
	c_sleep: cover property (pwr_state_o == PWR_SLEEP);
	c_default: cover property ($rose(boot_done_o) && default_applied_o);
endmodule // boot_ctrl_monitor

// [testbench/cfg_loader_model.sv]
/* Outside configuration loader model.
   Answers a request after dly_i cycles: load or failure. */
`timescale 1ns/100ps

module cfg_loader_model
(
	// Clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_n_i,
	// Request and answer control
	input  wire logic       req_i,
	input  wire logic       ok_i,
	input  wire logic [2:0] dly_i,
	// Answer pulses
	output logic            loaded_o,
	output logic            failed_o
);
	logic [2:0] cnt_ff;
	wire fire = req_i && cnt_ff == dly_i && !loaded_o && !failed_o;
	// One pulse per attempt; repeats while the request stays up
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			{cnt_ff, loaded_o, failed_o} <= '0;
		else
		begin
			loaded_o <= fire && ok_i;
			failed_o <= fire && !ok_i;
			cnt_ff   <= (req_i && cnt_ff != dly_i) ? cnt_ff + 3'h1 : 3'h0;
		end
	end
endmodule // cfg_loader_model

// [testbench/boot_strap_power_state_ctrl_tb_top.sv]
/* Self-checking bench: strap bands, boot paths, power states.
   Assumes the loader model and bound checker. */
`timescale 1ns/100ps

module boot_strap_power_state_ctrl_tb_top;
	import boot_pkg::*;
	// Nibble k: mode or config code of band k tenths, in enum order
	localparam logic [39:0] M1 = 40'h5555423100, C1 = 40'h0000101000;
	localparam logic [39:0] M0 = 40'h5050453000, C0 = 40'h6775141320;
	logic clk_sys_i, rst_n_i, strap_pin_i, ratio_valid_i, main_supply_input_i;
	logic regulated_3v3_from_vbus_i, cfg_loaded_i, cfg_failed_i, cfg_ext_switch_i;
	logic idle_req_i, sleep_req_i, port_connected_i, attach_detach_i, pd_msg_i;
	logic i2c_traffic_i, cfg_load_req_o, boot_done_o, default_applied_o, lm, p;
	logic port1_ext_path_ctrl_o, port2_ext_path_ctrl_o, ports_disabled_o;
	logic legacy_sink_o, sink_only_o, pd_msg_discard_o;
	logic [6:0] strap_divider_input_i, r;
	logic [1:0] vbus_present_i, int_switch_en_o, vb;
	logic [2:0] dly;
	logic [31:0] seed = 32'h0000679F, x;
	strap_s strap_o, e;
	profile_s profile_o;
	power_state_e pwr_state_o;
	pwr_ctrl_s pwr_ctrl_o;
	int failures = 0, num_checks = 0;
	wire logic [4:0] sw = {cfg_load_req_o, int_switch_en_o, port1_ext_path_ctrl_o,
		port2_ext_path_ctrl_o};

	boot_strap_power_state_ctrl u_dut (.*);
	cfg_loader_model u_ldr (.clk_i(clk_sys_i), .rst_n_i, .req_i(cfg_load_req_o), .ok_i(lm),
		.dly_i(dly), .loaded_o(cfg_loaded_i), .failed_o(cfg_failed_i));

	// Helpers: random source, expectations, checks
	function logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic strap_s exp_strap(input logic pin, input logic [6:0] v);
		int k;
		logic [39:0] m, c;
		k = (v == 7'h64) ? 9 : v / 10;
		m = pin ? M1 : M0;
		c = pin ? C1 : C0;
		if (pin ? (v % 10 == 9 && v > 9 && v < 60) : (v < 10 || (v % 10 == 9 && v < 90)))
			return '{1'b0, db_no_response, CFG_SAFE};
		return '{1'b1, db_mode_e'(m[k*4 +: 3]), default_cfg_e'(c[k*4 +: 3])};
	endfunction
	function automatic profile_s exp_prof(input default_cfg_e c);
		profile_s f;
		logic snk;
		f = '0;
		snk = c inside {CFG_SET3, CFG_SET5};
		f.dfp_en = c inside {CFG_SET1, CFG_SET2, CFG_SET4};
		f.ufp_en = snk;
		f.ext_switch = c == CFG_SET5;
		f.pd_en = c inside {CFG_SET2, CFG_SET3, CFG_SET4, CFG_SET5};
		f.src_watts = c inside {CFG_SET1, CFG_SET5} ? SRC_W_15 : c == CFG_SET2 ? SRC_W_45
			: c == CFG_SET4 ? SRC_W_60 : SRC_W_NONE;
		f.src_vmask = c inside {CFG_SET2, CFG_SET4} ? VMASK_ALL
			: c inside {CFG_SET1, CFG_SET5} ? VMASK_5V : VMASK_NONE;
		if (snk)
			{f.snk_v_min, f.snk_v_max, f.snk_i_min, f.snk_i_max} =
				{SNK_V_MIN, SNK_V_MAX, SNK_I_MIN, SNK_I_MAX};
		return f;
	endfunction
	task chk(input logic [63:0] g, input logic [63:0] w);
		num_checks++;
		if (g !== w)
		begin
			failures++;
			$display("unexpected at %0t: got %h expected %h", $time, g, w);
		end
	endtask
	task cyc(input int n);
		repeat (n) @(negedge clk_sys_i);
	endtask
	task wt(input int n);
		repeat (n) if (boot_done_o !== 1'b1) @(negedge clk_sys_i);
	endtask
	task start();
		{rst_n_i, main_supply_input_i, ratio_valid_i} = 3'h1;
		{strap_pin_i, strap_divider_input_i, vbus_present_i} = {p, r, vb};
		cyc(16);
		rst_n_i = 1'b1;
	endtask
	task stop_test();
		$display("checks %0d mismatches %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// Clock
	initial
	begin
		clk_sys_i = 1'b0;
		forever #20 clk_sys_i = ~clk_sys_i;
	end
	// Watchdog
	initial
	begin
		#400000;
		failures++;
		stop_test();
	end
	// Strap bands, boot paths, then power states
	initial
	begin
		{strap_pin_i, strap_divider_input_i, ratio_valid_i, main_supply_input_i} = '0;
		{vbus_present_i, regulated_3v3_from_vbus_i, cfg_ext_switch_i, idle_req_i} = '0;
		{sleep_req_i, port_connected_i, attach_detach_i, pd_msg_i, i2c_traffic_i} = '0;
		{lm, dly, p, r, vb} = '0;
		for (int i = 0; i < 20; i++)
		begin
			x = xs();
			p = i >= 10;
			r = (i == 0) ? 7'(x % 10) : 7'((i % 10) * 10 + x[7:0] % 9);
			if (i % 10 == 9 && x[20])
				r = 7'h64;
			{vb, lm, dly, cfg_ext_switch_i} = {x[9] ? 2'h1 : 2'h2, 1'b0, x[12:10], x[13]};
			e = exp_strap(p, r);
			start();
			cyc(3);
			chk(strap_o, e);
			{strap_pin_i, strap_divider_input_i} = {~p, ~r};
			cyc(8);
			chk(strap_o, e);
			if (e.mode == db_no_response)
				chk(sw, 5'h00);
			if (e.mode == db_wait_supply_internal)
				chk(sw, {1'b0, vb, 2'h0});
			if (e.mode == db_wait_supply_external)
				chk(sw, {3'h0, vb[0], vb[1]});
			main_supply_input_i = 1'b1;
			wt(40);
			if (e.mode inside {db_controller_wait_internal, db_controller_wait_external})
			begin
				chk(boot_done_o, 1'b0);
				lm = 1'b1;
				wt(40);
				chk({boot_done_o, default_applied_o}, 2'h2);
			end
			else
			begin
				chk({boot_done_o, default_applied_o}, 2'h3);
				chk(profile_o, exp_prof(e.cfg));
				cyc(2);
				chk(ports_disabled_o, e.cfg inside {CFG_SAFE, CFG_RESERVED});
				main_supply_input_i = 1'b0;
				cyc(3);
				chk(legacy_sink_o, e.cfg inside {CFG_SAFE, CFG_RESERVED});
			end
			$display("strap case %0d done", i);
		end
		idle_req_i = 1'b1;
		cyc(2);
		chk(pwr_state_o, PWR_IDLE);
		{idle_req_i, pd_msg_i} = 2'h1;
		cyc(1);
		pd_msg_i = 1'b0;
		chk({pwr_state_o, pd_msg_discard_o}, {PWR_ACTIVE, 1'b1});
		sleep_req_i = 1'b1;
		cyc(2);
		chk(pwr_state_o, PWR_SLEEP);
		pd_msg_i = 1'b1;
		cyc(3);
		chk(pwr_state_o, PWR_SLEEP);
		{pd_msg_i, sleep_req_i, i2c_traffic_i} = 3'h1;
		cyc(1);
		{i2c_traffic_i, port_connected_i, sleep_req_i} = 3'h3;
		chk(pwr_state_o, PWR_ACTIVE);
		cyc(3);
		chk(pwr_state_o, PWR_ACTIVE);
		repeat (400)
		begin
			x = xs();
			{idle_req_i, sleep_req_i, port_connected_i, regulated_3v3_from_vbus_i} = x[3:0];
			{attach_detach_i, pd_msg_i, i2c_traffic_i} = {&x[5:4], &x[7:6], &x[9:8]};
			cyc(1);
		end
		$display("power state test done");
		stop_test();
	end
endmodule // boot_strap_power_state_ctrl_tb_top

bind boot_strap_power_state_ctrl boot_ctrl_monitor u_mon (.*);
